// file: verilog/gpio_params.svh
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_PORT_A_DATA       10'h005
`define IDX_PORT_B_DATA       10'h006
`define IDX_PORT_C_DATA       10'h007
`define IDX_INTERRUPT_CONTROL 10'h00b
`define IDX_GLOBAL_OPTIONS    10'h081
`define IDX_PORT_A_DIRECTION  10'h085
`define IDX_PORT_B_DIRECTION  10'h086
`define IDX_PORT_C_DIRECTION  10'h087

`define AXI_ADDR_WIDTH        12

// Reset values
`define RST_OPTIONS           8'hff
`define RST_DIR_A             6'h3f
`define RST_DIR_B             8'hff
`define RST_DIR_C             8'hff
`define RST_LATCH_A           6'h00
`define RST_LATCH_B           8'h00
`define RST_LATCH_C           8'h00

// Field positions
`define BIT_PULLUP_DISABLE_N  7
`define BIT_IRQ_EDGE_SELECT   6
`define BIT_PORT_CHANGE_FLAG  0
`define BIT_TIMER0_CLOCK      4
`define BIT_SLAVE_SELECT      5
`define BIT_EXT_IRQ           0

`endif

// file: verilog/gpio_pkg.sv
package gpio_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [5:0] port_a_t;
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;
endpackage

// file: verilog/gpio_ports_with_change_irq.sv
`include "gpio_params.svh"
`timescale 1ns/1ps
`default_nettype none

module gpio_ports_with_change_irq (
    input  wire logic                         core_clk,
    input  wire logic                         reset,
    // AXI4-Lite slave
    input  wire logic [`AXI_ADDR_WIDTH-1:0]   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output gpio_pkg::axi_resp_t               s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [`AXI_ADDR_WIDTH-1:0]   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output gpio_pkg::axi_resp_t               s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // Port A pins
    input  wire gpio_pkg::port_a_t            port_a_pin_in,
    output gpio_pkg::port_a_t                 port_a_pin_out,
    output gpio_pkg::port_a_t                 port_a_pin_oe,
    // Port B pins
    input  wire gpio_pkg::byte_t              port_b_pin_in,
    output gpio_pkg::byte_t                   port_b_pin_out,
    output gpio_pkg::byte_t                   port_b_pin_oe,
    output gpio_pkg::byte_t                   port_b_pullup_en,
    // Port C pins and peripheral overrides
    input  wire gpio_pkg::byte_t              port_c_pin_in,
    output gpio_pkg::byte_t                   port_c_pin_out,
    output gpio_pkg::byte_t                   port_c_pin_oe,
    input  wire gpio_pkg::byte_t              periph_enable,
    input  wire gpio_pkg::byte_t              periph_out,
    input  wire gpio_pkg::byte_t              periph_oe,
    output gpio_pkg::byte_t                   port_c_level,
    // Alternate functions and events
    output logic                              timer0_clock_pin,
    output logic                              slave_select_n,
    output logic                              ext_irq_pin,
    output logic                              ext_irq_event,
    output logic                              port_change_flag,
    output logic                              wake_request
);
    import gpio_pkg::*;

    // Two-stage synchronisers; stage one is read by stage two only
    port_a_t   sync1_a;
    port_a_t   sync2_a;
    byte_t     sync1_b;
    byte_t     sync2_b;
    byte_t     sync1_c;
    byte_t     sync2_c;

    always_ff @(posedge core_clk) begin
        sync1_a <= port_a_pin_in;
        sync2_a <= sync1_a;
        sync1_b <= port_b_pin_in;
        sync2_b <= sync1_b;
        sync1_c <= port_c_pin_in;
        sync2_c <= sync1_c;
    end

    // Registers
    port_a_t   latch_a;
    byte_t     latch_b;
    byte_t     latch_c;
    port_a_t   port_a_direction;
    byte_t     port_b_direction;
    byte_t     port_c_direction;
    byte_t     global_options_reg;
    logic      [7:4] change_reference;
    logic      prev_irq_level;
    logic      irq_armed;

    // Bus slave state
    logic      aw_held;
    logic      w_held;
    logic      [`AXI_ADDR_WIDTH-1:0] aw_addr;
    logic      [31:0] w_data;
    logic      [3:0]  w_strb;

    function automatic logic [9:0] reg_index(input logic [`AXI_ADDR_WIDTH-1:0] addr);
        reg_index = addr[`AXI_ADDR_WIDTH-1:2];
    endfunction

    function automatic logic is_mapped(input logic [9:0] idx);
        is_mapped = (idx == `IDX_PORT_A_DATA) || (idx == `IDX_PORT_B_DATA) ||
                    (idx == `IDX_PORT_C_DATA) || (idx == `IDX_INTERRUPT_CONTROL) ||
                    (idx == `IDX_GLOBAL_OPTIONS) || (idx == `IDX_PORT_A_DIRECTION) ||
                    (idx == `IDX_PORT_B_DIRECTION) || (idx == `IDX_PORT_C_DIRECTION);
    endfunction

    // Write side decode
    wire       write_fire = aw_held && w_held && !s_axi_bvalid;
    wire [9:0] wr_idx     = reg_index(aw_addr);
    wire       wr_lane0   = write_fire && w_strb[0];
    wire       wr_pa      = wr_lane0 && (wr_idx == `IDX_PORT_A_DATA);
    wire       wr_pb      = wr_lane0 && (wr_idx == `IDX_PORT_B_DATA);
    wire       wr_pc      = wr_lane0 && (wr_idx == `IDX_PORT_C_DATA);
    wire       wr_icr     = wr_lane0 && (wr_idx == `IDX_INTERRUPT_CONTROL);
    wire       wr_opt     = wr_lane0 && (wr_idx == `IDX_GLOBAL_OPTIONS);
    wire       wr_da      = wr_lane0 && (wr_idx == `IDX_PORT_A_DIRECTION);
    wire       wr_db      = wr_lane0 && (wr_idx == `IDX_PORT_B_DIRECTION);
    wire       wr_dc      = wr_lane0 && (wr_idx == `IDX_PORT_C_DIRECTION);

    // Read side decode
    wire       read_fire  = s_axi_arvalid && s_axi_arready;
    wire [9:0] rd_idx     = reg_index(s_axi_araddr);
    wire       rd_pb      = read_fire && (rd_idx == `IDX_PORT_B_DATA);

    // Data reads see the pins, not the latch
    byte_t     read_value;
    always_comb begin
        read_value = 8'h00;
        case (rd_idx)
            `IDX_PORT_A_DATA:       read_value = {2'b00, sync2_a};
            `IDX_PORT_B_DATA:       read_value = sync2_b;
            `IDX_PORT_C_DATA:       read_value = sync2_c;
            `IDX_INTERRUPT_CONTROL: read_value = {7'h00, port_change_flag};
            `IDX_GLOBAL_OPTIONS:    read_value = global_options_reg;
            `IDX_PORT_A_DIRECTION:  read_value = {2'b00, port_a_direction};
            `IDX_PORT_B_DIRECTION:  read_value = port_b_direction;
            `IDX_PORT_C_DIRECTION:  read_value = port_c_direction;
            default:                read_value = 8'h00;
        endcase
    end

    // Change detection on the upper port B pins
    wire [7:4] watch_inputs  = port_b_direction[7:4];
    wire [7:4] pin_mismatch  = (sync2_b[7:4] ^ change_reference) & watch_inputs;
    wire       any_mismatch  = |pin_mismatch;
    wire       next_flag     = any_mismatch ? 1'b1 :
                               (wr_icr ? w_data[`BIT_PORT_CHANGE_FLAG] : port_change_flag);

    // Pull-ups: active-low global enable, forced off on outputs
    wire       pullups_on     = !global_options_reg[`BIT_PULLUP_DISABLE_N];
    wire byte_t next_pullup   = {8{pullups_on}} & port_b_direction;

    // External interrupt edge, polarity from the options register
    wire       irq_level      = sync2_b[`BIT_EXT_IRQ];
    wire       irq_rise       = irq_level && !prev_irq_level;
    wire       irq_fall       = !irq_level && prev_irq_level;
    // The first level after reset only loads the detector, so a floating pin gives no false edge
    wire       next_irq_event = irq_armed &&
                                (global_options_reg[`BIT_IRQ_EDGE_SELECT] ? irq_rise : irq_fall);

    // Port C pin selection; peripheral wins while enabled
    wire byte_t next_c_oe     = (periph_enable & periph_oe) |
                                (~periph_enable & ~port_c_direction);
    wire byte_t next_c_out    = (periph_enable & periph_out) |
                                (~periph_enable & latch_c);

    // Port A: pin 4 only ever pulls low
    port_a_t   next_a_oe;
    port_a_t   next_a_out;
    always_comb begin
        next_a_oe  = ~port_a_direction;
        next_a_out = latch_a;
        next_a_oe[`BIT_TIMER0_CLOCK]  = !port_a_direction[`BIT_TIMER0_CLOCK] &&
                                        !latch_a[`BIT_TIMER0_CLOCK];
        next_a_out[`BIT_TIMER0_CLOCK] = 1'b0;
    end

    // Data latches hold across bus activity; reset clears them for a defined start
    always_ff @(posedge core_clk) begin
        if (reset) begin
            latch_a <= `RST_LATCH_A;
            latch_b <= `RST_LATCH_B;
            latch_c <= `RST_LATCH_C;
        end else begin
            if (wr_pa) begin
                latch_a <= w_data[5:0];
            end
            if (wr_pb) begin
                latch_b <= w_data[7:0];
            end
            if (wr_pc) begin
                latch_c <= w_data[7:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            port_a_direction   <= `RST_DIR_A;
            port_b_direction   <= `RST_DIR_B;
            port_c_direction   <= `RST_DIR_C;
            global_options_reg <= `RST_OPTIONS;
        end else begin
            if (wr_da) begin
                port_a_direction <= w_data[5:0];
            end
            if (wr_db) begin
                port_b_direction <= w_data[7:0];
            end
            if (wr_dc) begin
                port_c_direction <= w_data[7:0];
            end
            if (wr_opt) begin
                global_options_reg <= w_data[7:0];
            end
        end
    end

    // A port B data read, or a port B data write with lane 0 enabled, reloads the reference, ending a mismatch
    always_ff @(posedge core_clk) begin
        if (reset) begin
            change_reference <= 4'h0;
            port_change_flag <= 1'b0;
            wake_request     <= 1'b0;
            prev_irq_level   <= 1'b0;
            irq_armed        <= 1'b0;
            ext_irq_event    <= 1'b0;
        end else begin
            if (rd_pb || wr_pb) begin
                change_reference <= sync2_b[7:4];
            end
            port_change_flag <= next_flag;
            wake_request     <= next_flag;
            prev_irq_level   <= irq_level;
            irq_armed        <= 1'b1;
            ext_irq_event    <= next_irq_event;
        end
    end

    // Registered pin drivers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            port_a_pin_oe    <= 6'h00;
            port_a_pin_out   <= 6'h00;
            port_b_pin_oe    <= 8'h00;
            port_b_pin_out   <= 8'h00;
            port_b_pullup_en <= 8'h00;
            port_c_pin_oe    <= 8'h00;
            port_c_pin_out   <= 8'h00;
        end else begin
            port_a_pin_oe    <= next_a_oe;
            port_a_pin_out   <= next_a_out;
            port_b_pin_oe    <= ~port_b_direction;
            port_b_pin_out   <= latch_b;
            port_b_pullup_en <= next_pullup;
            port_c_pin_oe    <= next_c_oe;
            port_c_pin_out   <= next_c_out;
        end
    end

    // Alternate input functions, all from synchronised levels
    always_ff @(posedge core_clk) begin
        if (reset) begin
            timer0_clock_pin <= 1'b0;
            slave_select_n   <= 1'b1;
            ext_irq_pin      <= 1'b0;
            port_c_level     <= 8'h00;
        end else begin
            timer0_clock_pin <= sync2_a[`BIT_TIMER0_CLOCK];
            slave_select_n   <= sync2_a[`BIT_SLAVE_SELECT];
            ext_irq_pin      <= irq_level;
            port_c_level     <= sync2_c;
        end
    end

    // AXI4-Lite write channels, taken in either order
    always_ff @(posedge core_clk) begin
        if (reset) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) &&
                             !(s_axi_bvalid && !s_axi_bready);
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (write_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel; pins sampled at the address handshake
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !read_fire;
            if (read_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, read_value};
                s_axi_rresp  <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Polling port B reloads the reference and can hide a change
    // Port C direction reads return the stored bits, not the override

endmodule

`default_nettype wire

// file: bench/gpio_ports_with_change_irq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_with_change_irq_asserts
    import gpio_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                reset,
    input wire logic                s_axi_awready,
    input wire gpio_pkg::axi_resp_t s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    input wire gpio_pkg::port_a_t   port_a_pin_out,
    input wire gpio_pkg::byte_t     port_b_pin_oe,
    input wire gpio_pkg::byte_t     port_b_pullup_en,
    input wire gpio_pkg::byte_t     port_c_pin_out,
    input wire gpio_pkg::byte_t     port_c_pin_oe,
    input wire gpio_pkg::byte_t     periph_enable,
    input wire gpio_pkg::byte_t     periph_out,
    input wire gpio_pkg::byte_t     periph_oe,
    input wire logic                port_change_flag,
    input wire logic                wake_request
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_open_drain_a4: assert property (port_a_pin_out[4] == 1'b0)
        else $error("open drain pin drove high");
    // Three quiet cycles let the direction-driven outputs settle before comparing
    a_pullup_out_off: assert property ($stable(port_b_pin_oe) [*3] |->
        (port_b_pullup_en & port_b_pin_oe) == 8'h00) else $error("pull-up on output pin");
    a_flag_clear_path: assert property ($fell(port_change_flag) |-> $rose(s_axi_bvalid))
        else $error("change flag fell without a register write");
    a_wake_follow: assert property ($rose(port_change_flag) |-> ##[0:1] wake_request)
        else $error("wake request missing after change flag");
    a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted while response pending");
    a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    a_c_override: assert property (($stable(periph_enable) && $stable(periph_oe)
        && $stable(periph_out)) [*3] |-> ((port_c_pin_oe ^ periph_oe) & periph_enable) == 8'h00
        && ((port_c_pin_out ^ periph_out) & periph_enable) == 8'h00)
        else $error("peripheral override not applied");
endmodule

bind gpio_ports_with_change_irq gpio_ports_with_change_irq_asserts u_chk (.core_clk, .reset,
    .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .port_a_pin_out, .port_b_pin_oe,
    .port_b_pullup_en, .port_c_pin_out, .port_c_pin_oe, .periph_enable, .periph_out,
    .periph_oe, .port_change_flag, .wake_request);
`default_nettype wire

// file: bench/gpio_pin_world.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_world
    import gpio_pkg::*;
(
    input  wire logic            core_clk,
    input  wire gpio_pkg::byte_t a_out,
    input  wire gpio_pkg::byte_t a_oe,
    input  wire gpio_pkg::byte_t a_ext_en,
    input  wire gpio_pkg::byte_t a_ext_val,
    output logic [5:0]           a_in,
    input  wire gpio_pkg::byte_t b_out,
    input  wire gpio_pkg::byte_t b_oe,
    input  wire gpio_pkg::byte_t b_pu,
    input  wire gpio_pkg::byte_t b_ext_en,
    input  wire gpio_pkg::byte_t b_ext_val,
    output gpio_pkg::byte_t      b_in,
    input  wire gpio_pkg::byte_t c_out,
    input  wire gpio_pkg::byte_t c_oe,
    output gpio_pkg::byte_t      c_in
);
    import gpio_pkg::*;
    byte_t float_q = 8'h55;
    byte_t a_full;
    // Undriven lines without pull-up wander, so no test can lean on a stale level
    always_ff @(posedge core_clk) float_q <= ~float_q;
    // The wandering level is an argument so the assigns follow it
    function automatic byte_t resolve(byte_t o, byte_t oe, byte_t en, byte_t v, byte_t pu,
                                      byte_t f);
        return (oe & o) | (~oe & en & v) | (~oe & ~en & pu) | (~oe & ~en & ~pu & f);
    endfunction
    assign a_full = resolve(a_out, a_oe, a_ext_en, a_ext_val, 8'h00, float_q);
    assign a_in   = a_full[5:0];
    assign b_in   = resolve(b_out, b_oe, b_ext_en, b_ext_val, b_pu, float_q);
    assign c_in   = resolve(c_out, c_oe, 8'h00, 8'h00, 8'h00, float_q);
endmodule
`default_nettype wire

// file: bench/gpio_ports_with_change_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_params.svh"
module gpio_ports_with_change_irq_tb;
    import gpio_pkg::*;
    typedef struct {logic [9:0] idx; byte_t wd; byte_t exp; axi_resp_t resp;} row_t;
    logic        core_clk = 1'b0, reset = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, timer0_clock_pin, slave_select_n, ext_irq_pin, ext_irq_event;
    logic        port_change_flag, wake_request;
    axi_resp_t   s_axi_bresp, s_axi_rresp, r;
    port_a_t     port_a_pin_in, port_a_pin_out, port_a_pin_oe;
    byte_t       port_b_pin_in, port_b_pin_out, port_b_pin_oe, port_b_pullup_en, d;
    byte_t       port_c_pin_in, port_c_pin_out, port_c_pin_oe, port_c_level;
    byte_t       periph_enable = 8'h00, periph_out = 8'h00, periph_oe = 8'h00;
    byte_t       a_ext_en = 8'h30, a_ext_val = 8'h10, b_ext_en = 8'h00, b_ext_val = 8'h00;
    int          n_mismatch = 0, total_checks = 0, cycles = 0, n;
    row_t        rows [5] = '{
        '{`IDX_PORT_A_DIRECTION, 8'hff, 8'h3f, RESP_OKAY},
        '{`IDX_PORT_B_DIRECTION, 8'h5a, 8'h5a, RESP_OKAY},
        '{`IDX_GLOBAL_OPTIONS,   8'h7f, 8'h7f, RESP_OKAY},
        '{`IDX_PORT_C_DIRECTION, 8'h0f, 8'h0f, RESP_OKAY},
        '{10'h040,               8'hff, 8'h00, RESP_SLVERR}};

    gpio_ports_with_change_irq DUT (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_pin_in,
        .port_a_pin_out, .port_a_pin_oe, .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe,
        .port_b_pullup_en, .port_c_pin_in, .port_c_pin_out, .port_c_pin_oe, .periph_enable,
        .periph_out, .periph_oe, .port_c_level, .timer0_clock_pin, .slave_select_n,
        .ext_irq_pin, .ext_irq_event, .port_change_flag, .wake_request);
    gpio_pin_world pins (.core_clk, .a_out({2'b00, port_a_pin_out}), .a_oe({2'b00, port_a_pin_oe}),
        .a_ext_en, .a_ext_val, .a_in(port_a_pin_in), .b_out(port_b_pin_out),
        .b_oe(port_b_pin_oe), .b_pu(port_b_pullup_en), .b_ext_en, .b_ext_val,
        .b_in(port_b_pin_in), .c_out(port_c_pin_out), .c_oe(port_c_pin_oe), .c_in(port_c_pin_in));

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic axi_write(input logic [9:0] idx, input byte_t v, output axi_resp_t rs);
        @(posedge core_clk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [9:0] idx, output byte_t v, output axi_resp_t rs);
        @(posedge core_clk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v  = s_axi_rdata[7:0];
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic reg_write(input logic [9:0] idx, input byte_t v);
        axi_resp_t rs;
        axi_write(idx, v, rs);
        check("wr_resp", rs, RESP_OKAY);
    endtask
    task automatic read_expect(input string nm, input logic [9:0] idx, input byte_t exp);
        byte_t v;
        axi_resp_t rs;
        axi_read(idx, v, rs);
        check(nm, v, exp);
        check("rd_resp", rs, RESP_OKAY);
    endtask
    task automatic count_events(output int k);
        k = 0;
        repeat (8) begin
            @(posedge core_clk);
            if (ext_irq_event === 1'b1) k++;
        end
    endtask

    initial begin
        settle(3);
        reset <= 1'b0;
        settle(1);
        check("pullup_rst", port_b_pullup_en, 8'h00);
        read_expect("dir_b_rst", `IDX_PORT_B_DIRECTION, 8'hff);
        read_expect("opt_rst", `IDX_GLOBAL_OPTIONS, 8'hff);
        read_expect("dir_c_rst", `IDX_PORT_C_DIRECTION, 8'hff);
        foreach (rows[i]) begin
            axi_write(rows[i].idx, rows[i].wd, r);
            check("row_wr_resp", r, rows[i].resp);
            axi_read(rows[i].idx, d, r);
            check("row_rd_data", d, rows[i].exp);
            check("row_rd_resp", r, rows[i].resp);
        end
        check("b_oe_row", port_b_pin_oe, 8'ha5);
        check("b_pu_row", port_b_pullup_en, 8'h5a);
        reg_write(`IDX_PORT_B_DATA, 8'ha5);
        reg_write(`IDX_PORT_B_DIRECTION, 8'hf0);
        settle(4);
        check("b_oe", port_b_pin_oe, 8'h0f);
        check("b_out", port_b_pin_out, 8'ha5);
        check("b_pullup", port_b_pullup_en, 8'hf0);
        // Port B is read only at chosen moments so the reference is not disturbed
        read_expect("b_pins", `IDX_PORT_B_DATA, 8'hf5);
        reg_write(`IDX_INTERRUPT_CONTROL, 8'h00);
        settle(4);
        check("flag_clr", port_change_flag, 1'b0);
        b_ext_en  <= 8'h10;
        b_ext_val <= 8'h00;
        settle(6);
        check("flag_key", port_change_flag, 1'b1);
        check("wake_key", wake_request, 1'b1);
        reg_write(`IDX_INTERRUPT_CONTROL, 8'h00);
        settle(2);
        check("flag_held", port_change_flag, 1'b1);
        read_expect("b_key", `IDX_PORT_B_DATA, 8'he5);
        reg_write(`IDX_INTERRUPT_CONTROL, 8'h00);
        settle(2);
        check("flag_after", port_change_flag, 1'b0);
        reg_write(`IDX_PORT_B_DIRECTION, 8'hff);
        settle(6);
        check("flag_low_pins", port_change_flag, 1'b0);
        check("b_pullup_all", port_b_pullup_en, 8'hff);
        b_ext_en <= 8'h11;
        settle(6);
        b_ext_val <= 8'h01;
        count_events(n);
        check("irq_rise", n, 1);
        check("irq_level", ext_irq_pin, 1'b1);
        reg_write(`IDX_GLOBAL_OPTIONS, 8'h3f);
        b_ext_val <= 8'h00;
        count_events(n);
        check("irq_fall", n, 1);
        reg_write(`IDX_PORT_A_DATA, 8'h00);
        reg_write(`IDX_PORT_A_DIRECTION, 8'h20);
        settle(4);
        check("a_oe_low", port_a_pin_oe, 6'h1f);
        check("t0_low", timer0_clock_pin, 1'b0);
        reg_write(`IDX_PORT_A_DATA, 8'h10);
        settle(4);
        check("a_oe_rel", port_a_pin_oe, 6'h0f);
        check("a_out_od", port_a_pin_out, 6'h00);
        check("t0_high", timer0_clock_pin, 1'b1);
        check("ss_low", slave_select_n, 1'b0);
        read_expect("a_pins", `IDX_PORT_A_DATA, 8'h10);
        // Port C data and direction written before overrides enable, then checked with overrides on and off
        reg_write(`IDX_PORT_C_DATA, 8'h30);
        reg_write(`IDX_PORT_C_DIRECTION, 8'hf0);
        periph_enable <= 8'h0f;
        periph_oe     <= 8'h05;
        periph_out    <= 8'h0c;
        settle(4);
        check("c_oe_per", port_c_pin_oe, 8'h05);
        check("c_out_per", port_c_pin_out, 8'h3c);
        periph_enable <= 8'h00;
        settle(4);
        check("c_oe_port", port_c_pin_oe, 8'h0f);
        check("c_out_port", port_c_pin_out, 8'h30);
        settle(2);
        check("c_level", port_c_level[3:0], 4'h0);
        // A write with lane 0 off must leave the register alone
        s_axi_wstrb <= 4'he;
        reg_write(`IDX_PORT_C_DIRECTION, 8'h00);
        s_axi_wstrb <= 4'hf;
        read_expect("dir_c_strb", `IDX_PORT_C_DIRECTION, 8'hf0);
        reset <= 1'b1;
        settle(3);
        reset <= 1'b0;
        settle(1);
        check("pullup_rst2", port_b_pullup_en, 8'h00);
        read_expect("dir_a_rst2", `IDX_PORT_A_DIRECTION, 8'h3f);
        finish_test();
    end
endmodule
`default_nettype wire
